// ===== verilog/sbt_defs.vh
// Constants of the scan test bus transceiver: opcodes, register sizes,
// field positions, reset values. Included by the transceiver and the top bench.
`ifndef SBT_DEFS_VH
`define SBT_DEFS_VH

`define SBT_IR_W 8
`define SBT_IR_RESET 8'h81
`define SBT_IR_CAPTURE 8'h81

`define SBT_OP_IDENTIFICATION_READOUT 8'h81
`define SBT_OP_BYPASS 8'hff
`define SBT_OP_EXTEST 8'h00
`define SBT_OP_SAMPLE 8'h82
`define SBT_OP_BCRSCAN 8'h87
`define SBT_OP_RUNTEST 8'h09

`define SBT_BSR_W 84
`define SBT_BSR_RESET 84'hf00000000000000000000
`define SBT_BSR_AIN 17:0
`define SBT_BSR_AOUT 35:18
`define SBT_BSR_BIN 53:36
`define SBT_BSR_BOUT 71:54
`define SBT_BSR_CTL 83:72
`define SBT_BSR_OE 83:80
`define SBT_BSR_B_TO_A_OUTPUT_ENABLE_N 81:80
`define SBT_BSR_A_TO_B_OUTPUT_ENABLE_N 83:82
`define SBT_BSR_OE_RESET 4'hf

`define SBT_BCR_W 21
`define SBT_BCR_RESET 21'h000000
`define SBT_BCR_OP 1:0
`define SBT_BCR_PSA 2'h0
`define SBT_BCR_PSEUDO_RANDOM_PATTERN_GEN 2'h1
`define SBT_BCR_COUNT 2'h2

`define SBT_ID_W 32

`define SBT_SYN_W 51
`define SBT_SYN_RESET 51'h3f00000000000
`define SBT_SYN_AIN 17:0
`define SBT_SYN_BIN 35:18
`define SBT_SYN_B_TO_A_LATCH_ENABLE 37:36
`define SBT_SYN_A_TO_B_LATCH_ENABLE 39:38
`define SBT_SYN_B_TO_A_CLOCK 41:40
`define SBT_SYN_A_TO_B_CLOCK 43:42
`define SBT_SYN_B_TO_A_OUTPUT_ENABLE_N 45:44
`define SBT_SYN_A_TO_B_OUTPUT_ENABLE_N 47:46
`define SBT_SYN_CTL 47:36
`define SBT_SYN_TDI 48
`define SBT_SYN_TMS 49
`define SBT_SYN_TCK 50

`define SBT_FIFO_W 3
`define SBT_FIFO_D 8
`define SBT_FIFO_AW 3

`endif

// ===== verilog/sbt_fifo.v
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, async active-high reset, DEPTH a power of two.
`timescale 1ns/1ps
module sbt_fifo #(
   parameter WIDTH = 3,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire mclk,
   input wire reset,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   localparam [AW:0] FULLCNT = DEPTH;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_r;
   reg [AW-1:0] rdPtr_r;
   reg [AW:0] count_r;
   wire push = inValid & inReady;
   wire pull = outValid & outReady;

   assign inReady = (count_r != FULLCNT);
   assign outValid = (count_r != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_r];

   // Pointers wrap by overflow, hence the power-of-two depth
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pull) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
         if (push & ~pull) begin
            count_r <= count_r + 1'b1;
         end else if (pull & ~push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

   always @(posedge mclk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end
endmodule

// ===== verilog/sbt_scan_transceiver.v
// Scan test bus transceiver: 18-bit universal transceiver plus test port.
// Assumes all pins arrive asynchronously to mclk; tck is sampled, not a clock.
// Bus pins are split into in/out/oe; the bench resolves wires and pull-ups.
`timescale 1ns/1ps
`include "sbt_defs.vh"
module sbt_scan_transceiver #(
   // Identification value is arbitrary; bit 0 set as the scan convention asks
   parameter [31:0] ID_VALUE = 32'h0000a001
) (
   input wire mclk,
   input wire reset,
   input wire tck,
   input wire tms,
   input wire tdi,
   output wire tdo,
   output wire tdoOe,
   input wire [17:0] aIn,
   output wire [17:0] aOut,
   output wire [17:0] aOe,
   input wire [17:0] bIn,
   output wire [17:0] bOut,
   output wire [17:0] bOe,
   input wire [1:0] aToBOutputEnableN,
   input wire [1:0] bToAOutputEnableN,
   input wire [1:0] aToBLatchEnable,
   input wire [1:0] bToALatchEnable,
   input wire [1:0] aToBClock,
   input wire [1:0] bToAClock
);
   localparam [3:0] ST_TLR = 4'hf;
   localparam [3:0] ST_RTI = 4'hc;
   localparam [3:0] ST_SELDR = 4'h7;
   localparam [3:0] ST_CAPDR = 4'h6;
   localparam [3:0] ST_SHDR = 4'h2;
   localparam [3:0] ST_EX1DR = 4'h1;
   localparam [3:0] ST_PDR = 4'h3;
   localparam [3:0] ST_EX2DR = 4'h0;
   localparam [3:0] ST_UPDR = 4'h5;
   localparam [3:0] ST_SELIR = 4'h4;
   localparam [3:0] ST_CAPIR = 4'he;
   localparam [3:0] ST_SHIR = 4'ha;
   localparam [3:0] ST_EX1IR = 4'h9;
   localparam [3:0] ST_PIR = 4'hb;
   localparam [3:0] ST_EX2IR = 4'h8;
   localparam [3:0] ST_UPIR = 4'hd;

   localparam [2:0] OPC_BYPASS = 3'h0;
   localparam [2:0] OPC_IDENTIFICATION_READOUT = 3'h1;
   localparam [2:0] OPC_EXTEST = 3'h2;
   localparam [2:0] OPC_SAMPLE = 3'h3;
   localparam [2:0] OPC_BCRSCAN = 3'h4;
   localparam [2:0] OPC_RUNTEST = 3'h5;

   localparam [1:0] SEL_BSR = 2'h0;
   localparam [1:0] SEL_BCR = 2'h1;
   localparam [1:0] SEL_ID = 2'h2;
   localparam [1:0] SEL_BYP = 2'h3;

   function [3:0] nextState;
      input [3:0] s;
      input t;
      begin
         case (s)
            ST_TLR: nextState = t ? ST_TLR : ST_RTI;
            ST_RTI: nextState = t ? ST_SELDR : ST_RTI;
            ST_SELDR: nextState = t ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: nextState = t ? ST_EX1DR : ST_SHDR;
            ST_SHDR: nextState = t ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: nextState = t ? ST_UPDR : ST_PDR;
            ST_PDR: nextState = t ? ST_EX2DR : ST_PDR;
            ST_EX2DR: nextState = t ? ST_UPDR : ST_SHDR;
            ST_UPDR: nextState = t ? ST_SELDR : ST_RTI;
            ST_SELIR: nextState = t ? ST_TLR : ST_CAPIR;
            ST_CAPIR: nextState = t ? ST_EX1IR : ST_SHIR;
            ST_SHIR: nextState = t ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: nextState = t ? ST_UPIR : ST_PIR;
            ST_PIR: nextState = t ? ST_EX2IR : ST_PIR;
            ST_EX2IR: nextState = t ? ST_UPIR : ST_SHIR;
            ST_UPIR: nextState = t ? ST_SELDR : ST_RTI;
            default: nextState = ST_TLR;
         endcase
      end
   endfunction

   function [2:0] decodeOp;
      input [7:0] op;
      begin
         if (^op) begin
            decodeOp = OPC_BYPASS;
         end else begin
            case (op)
               `SBT_OP_IDENTIFICATION_READOUT: decodeOp = OPC_IDENTIFICATION_READOUT;
               `SBT_OP_EXTEST: decodeOp = OPC_EXTEST;
               `SBT_OP_SAMPLE: decodeOp = OPC_SAMPLE;
               `SBT_OP_BCRSCAN: decodeOp = OPC_BCRSCAN;
               `SBT_OP_RUNTEST: decodeOp = OPC_RUNTEST;
               default: decodeOp = OPC_BYPASS;
            endcase
         end
      end
   endfunction

   // One LFSR step; an all-zero seed stays zero, so seed by scan first
   function [17:0] lfsr18;
      input [17:0] v;
      begin
         lfsr18 = {v[16:0], v[17] ^ v[10]};
      end
   endfunction

   // per-half control spread over nine bits
   function [17:0] halfExp;
      input [1:0] c;
      begin
         halfExp = {{9{c[1]}}, {9{c[0]}}};
      end
   endfunction

   reg [`SBT_SYN_W-1:0] sync1_r;
   reg [`SBT_SYN_W-1:0] sync2_r;
   reg prevTck_r;
   reg [3:0] prevClk_r;
   reg busy_r;
   reg [3:0] state_r;
   reg [7:0] irShift_r;
   reg [7:0] instr_r;
   reg [`SBT_BSR_W-1:0] bsrShift_r;
   reg [`SBT_BSR_W-1:0] bsrHold_r;
   reg [`SBT_BCR_W-1:0] bcrShift_r;
   reg [`SBT_BCR_W-1:0] bcrHold_r;
   reg [`SBT_ID_W-1:0] idShift_r;
   reg bypass_r;
   reg tdo_r;
   reg tdoOe_r;
   reg [17:0] abHeld_r;
   reg [17:0] baHeld_r;
   reg [17:0] aOut_r;
   reg [17:0] aOe_r;
   reg [17:0] bOut_r;
   reg [17:0] bOe_r;
   reg [1:0] sel;
   reg serialBit;

   wire [17:0] aInS = sync2_r[`SBT_SYN_AIN];
   wire [17:0] bInS = sync2_r[`SBT_SYN_BIN];
   wire [1:0] leAbS = sync2_r[`SBT_SYN_A_TO_B_LATCH_ENABLE];
   wire [1:0] leBaS = sync2_r[`SBT_SYN_B_TO_A_LATCH_ENABLE];
   wire [1:0] clkAbS = sync2_r[`SBT_SYN_A_TO_B_CLOCK];
   wire [1:0] clkBaS = sync2_r[`SBT_SYN_B_TO_A_CLOCK];
   wire [1:0] oeAbNS = sync2_r[`SBT_SYN_A_TO_B_OUTPUT_ENABLE_N];
   wire [1:0] oeBaNS = sync2_r[`SBT_SYN_B_TO_A_OUTPUT_ENABLE_N];
   wire tckS = sync2_r[`SBT_SYN_TCK];
   wire tckRise = tckS & ~prevTck_r;
   wire tckFall = ~tckS & prevTck_r;
   wire fifoInReady;
   wire fifoOutValid;
   wire [2:0] fifoOut;
   wire pop = fifoOutValid & ~busy_r;
   wire riseEv = pop & fifoOut[2];
   wire fallEv = pop & ~fifoOut[2];
   wire evTms = fifoOut[1];
   wire evTdi = fifoOut[0];
   wire [2:0] op = decodeOp(instr_r);
   wire testMode = (op == OPC_EXTEST) | (op == OPC_RUNTEST);
   wire [35:0] countNxt = {bsrHold_r[`SBT_BSR_BOUT], bsrHold_r[`SBT_BSR_AOUT]} + 36'h000000001;
   wire [1:0] clkAbRise = clkAbS & ~prevClk_r[3:2];
   wire [1:0] clkBaRise = clkBaS & ~prevClk_r[1:0];
   // transparent or edge capture, gated off in test mode
   wire [17:0] abMask = halfExp(leAbS | clkAbRise) & {18{~testMode}};
   // mirror path for B to A
   wire [17:0] baMask = halfExp(leBaS | clkBaRise) & {18{~testMode}};
   // hold when neither enable nor edge
   wire [17:0] abHeldNxt = (aInS & abMask) | (abHeld_r & ~abMask);
   wire [17:0] baHeldNxt = (bInS & baMask) | (baHeld_r & ~baMask);

   assign tdo = tdo_r;
   assign tdoOe = tdoOe_r;
   assign aOut = aOut_r;
   assign aOe = aOe_r;
   assign bOut = bOut_r;
   assign bOe = bOe_r;

   // undriven mode select and data input read high from reset
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         sync1_r <= `SBT_SYN_RESET;
         sync2_r <= `SBT_SYN_RESET;
      end else begin
         sync1_r <= {tck, tms, tdi, aToBOutputEnableN, bToAOutputEnableN, aToBClock,
                     bToAClock, aToBLatchEnable, bToALatchEnable, bIn, aIn};
         sync2_r <= sync1_r;
      end
   end

   // Edge tracker stalls while the FIFO is full so no tck edge is lost
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         prevTck_r <= 1'b0;
         prevClk_r <= 4'h0;
         busy_r <= 1'b0;
      end else begin
         if (fifoInReady) begin
            prevTck_r <= tckS;
         end
         prevClk_r <= {clkAbS, clkBaS};
         // Gap after each event lets update effects settle
         busy_r <= pop;
      end
   end

   sbt_fifo #(
      .WIDTH(`SBT_FIFO_W),
      .DEPTH(`SBT_FIFO_D),
      .AW(`SBT_FIFO_AW)
   ) u_edgeFifo (
      .mclk(mclk),
      .reset(reset),
      .inValid(tckRise | tckFall),
      .inReady(fifoInReady),
      .inData({tckRise, sync2_r[`SBT_SYN_TMS], sync2_r[`SBT_SYN_TDI]}),
      .outValid(fifoOutValid),
      .outReady(~busy_r),
      .outData(fifoOut)
   );

   // one data register chosen per instruction
   always @* begin
      case (op)
         OPC_IDENTIFICATION_READOUT: sel = SEL_ID;
         OPC_BCRSCAN: sel = SEL_BCR;
         OPC_EXTEST: sel = SEL_BSR;
         OPC_SAMPLE: sel = SEL_BSR;
         OPC_RUNTEST: sel = SEL_BSR;
         default: sel = SEL_BYP;
      endcase
   end

   // serial output from instruction or selected register
   always @* begin
      if (state_r == ST_SHIR) begin
         serialBit = irShift_r[0];
      end else begin
         case (sel)
            SEL_BSR: serialBit = bsrShift_r[0];
            SEL_BCR: serialBit = bcrShift_r[0];
            SEL_ID: serialBit = idShift_r[0];
            default: serialBit = bypass_r;
         endcase
      end
   end

   // reset puts controller in reset state
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= ST_TLR;
         irShift_r <= `SBT_IR_RESET;
         instr_r <= `SBT_IR_RESET;
         bsrShift_r <= `SBT_BSR_RESET;
         bsrHold_r <= `SBT_BSR_RESET;
         bcrShift_r <= `SBT_BCR_RESET;
         bcrHold_r <= `SBT_BCR_RESET;
         idShift_r <= 32'h00000000;
         bypass_r <= 1'b0;
         tdo_r <= 1'b0;
         tdoOe_r <= 1'b0;
      end else if (riseEv) begin
         // rising edge samples mode select and data
         state_r <= nextState(state_r, evTms);
         case (state_r)
            ST_CAPIR: begin
               irShift_r <= `SBT_IR_CAPTURE;
            end
            ST_SHIR: begin
               irShift_r <= {evTdi, irShift_r[7:1]};
            end
            ST_CAPDR: begin
               case (sel)
                  SEL_BSR: begin
                     if (op == OPC_RUNTEST) begin
                        bsrShift_r <= bsrHold_r;
                     end else begin
                        // separate input and output cells per pin
                        bsrShift_r <= {sync2_r[`SBT_SYN_CTL], bsrHold_r[`SBT_BSR_BOUT], bInS,
                                       bsrHold_r[`SBT_BSR_AOUT], aInS};
                     end
                  end
                  SEL_BCR: bcrShift_r <= bcrHold_r;
                  SEL_ID: idShift_r <= ID_VALUE;
                  default: bypass_r <= 1'b0;
               endcase
            end
            ST_SHDR: begin
               case (sel)
                  SEL_BSR: bsrShift_r <= {evTdi, bsrShift_r[`SBT_BSR_W-1:1]};
                  SEL_BCR: bcrShift_r <= {evTdi, bcrShift_r[`SBT_BCR_W-1:1]};
                  SEL_ID: idShift_r <= {evTdi, idShift_r[`SBT_ID_W-1:1]};
                  default: bypass_r <= evTdi;
               endcase
            end
            ST_RTI: begin
               if (op == OPC_RUNTEST) begin
                  case (bcrHold_r[`SBT_BCR_OP])
                     `SBT_BCR_PSA: begin
                        bsrHold_r[`SBT_BSR_AIN] <= lfsr18(bsrHold_r[`SBT_BSR_AIN]) ^ aInS;
                        bsrHold_r[`SBT_BSR_BIN] <= lfsr18(bsrHold_r[`SBT_BSR_BIN]) ^ bInS;
                     end
                     `SBT_BCR_PSEUDO_RANDOM_PATTERN_GEN: begin
                        bsrHold_r[`SBT_BSR_AOUT] <= lfsr18(bsrHold_r[`SBT_BSR_AOUT]);
                        bsrHold_r[`SBT_BSR_BOUT] <= lfsr18(bsrHold_r[`SBT_BSR_BOUT]);
                     end
                     `SBT_BCR_COUNT: begin
                        bsrHold_r[`SBT_BSR_AIN] <= lfsr18(bsrHold_r[`SBT_BSR_AIN]) ^ aInS;
                        bsrHold_r[`SBT_BSR_BIN] <= lfsr18(bsrHold_r[`SBT_BSR_BIN]) ^ bInS;
                        bsrHold_r[`SBT_BSR_AOUT] <= countNxt[17:0];
                        bsrHold_r[`SBT_BSR_BOUT] <= countNxt[35:18];
                     end
                     default: begin
                        bsrHold_r <= bsrHold_r;
                     end
                  endcase
               end
            end
            default: begin
               bypass_r <= bypass_r;
            end
         endcase
      end else if (fallEv) begin
         // outputs and updates on falling edge
         tdoOe_r <= (state_r == ST_SHIR) | (state_r == ST_SHDR);
         tdo_r <= serialBit;
         case (state_r)
            ST_TLR: begin
               instr_r <= `SBT_IR_RESET;
               bsrHold_r[`SBT_BSR_OE] <= `SBT_BSR_OE_RESET;
               bcrHold_r <= `SBT_BCR_RESET;
            end
            ST_UPIR: begin
               instr_r <= irShift_r;
            end
            ST_UPDR: begin
               if (sel == SEL_BSR) begin
                  bsrHold_r <= bsrShift_r;
               end else if (sel == SEL_BCR) begin
                  bcrHold_r <= bcrShift_r;
               end
            end
            default: begin
               instr_r <= instr_r;
            end
         endcase
      end
   end

   // Transceiver storage runs outside test mode and holds its value while EXTEST or RUNTEST is the instruction
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         abHeld_r <= 18'h00000;
         baHeld_r <= 18'h00000;
      end else begin
         abHeld_r <= abHeldNxt;
         baHeld_r <= baHeldNxt;
      end
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         aOut_r <= 18'h00000;
         aOe_r <= 18'h00000;
         bOut_r <= 18'h00000;
         bOe_r <= 18'h00000;
      end else if (testMode) begin
         // boundary cells drive pins in test mode
         bOut_r <= bsrHold_r[`SBT_BSR_BOUT];
         bOe_r <= ~halfExp(bsrHold_r[`SBT_BSR_A_TO_B_OUTPUT_ENABLE_N]);
         aOut_r <= bsrHold_r[`SBT_BSR_AOUT];
         aOe_r <= ~halfExp(bsrHold_r[`SBT_BSR_B_TO_A_OUTPUT_ENABLE_N]);
      end else begin
         // normal path independent of scan activity
         bOut_r <= abHeldNxt;
         bOe_r <= ~halfExp(oeAbNS);
         aOut_r <= baHeldNxt;
         aOe_r <= ~halfExp(oeBaNS);
      end
   end

   // five high mode-select cycles reach reset via nextState
endmodule

// ===== tb/sbt_scan_transceiver_asserts.sv
// Pin-level checker for the scan test bus transceiver.
// Assumes it is bound to the top module and that tck stands low between frames.
`timescale 1ns/1ps
module sbt_asserts (
   input wire mclk,
   input wire reset,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire tdo,
   input wire tdoOe,
   input wire [17:0] aIn,
   input wire [17:0] aOut,
   input wire [17:0] aOe,
   input wire [17:0] bIn,
   input wire [17:0] bOut,
   input wire [17:0] bOe,
   input wire [1:0] aToBOutputEnableN,
   input wire [1:0] bToAOutputEnableN,
   input wire [1:0] aToBLatchEnable,
   input wire [1:0] bToALatchEnable,
   input wire [1:0] aToBClock,
   input wire [1:0] bToAClock
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Half 0 clock rises while its latch is shut
   sequence abRise;
      !aToBLatchEnable[0] && !aToBClock[0] ##1 !aToBLatchEnable[0] && aToBClock[0];
   endsequence
   // Data held still until the stored value must show
   sequence aQuiet;
      (!aToBLatchEnable[0] && $stable(aIn[8:0])) [*5];
   endsequence
   // First edge of reset has not cleared the flops yet
   reset_quiet_a: assert property (disable iff (1'b0)
      reset && $past(reset) |-> (aOe == 18'h0 && bOe == 18'h0 && tdoOe == 1'b0))
      else $error("outputs active during reset");
   tdo_fall_a: assert property (($changed(tdo) || $changed(tdoOe)) |-> !$past(tck, 2))
      else $error("serial output moved outside the low tck phase");
   b_hiz_low_a: assert property (aToBOutputEnableN[0] [*4] |-> bOe[8:0] == 9'h0)
      else $error("low half of B driven while disabled");
   b_hiz_high_a: assert property (aToBOutputEnableN[1] [*4] |-> bOe[17:9] == 9'h0)
      else $error("high half of B driven while disabled");
   pass_thru_a: assert property ((aToBLatchEnable[0] && $stable(aIn[8:0])) [*6]
      |-> bOut[8:0] == aIn[8:0])
      else $error("transparent path does not follow A");
   hold_data_a: assert property ((!aToBLatchEnable[0] && !aToBClock[0]
      && bOe[8:0] == 9'h1ff) [*8] |-> $stable(bOut[8:0]))
      else $error("latched B value moved");
   clk_store_a: assert property (abRise ##1 aQuiet |-> bOut[8:0] == aIn[8:0])
      else $error("clock rise did not store A");
   b_to_a_a: assert property ((bToALatchEnable[1] && $stable(bIn[17:9])) [*6]
      |-> aOut[17:9] == bIn[17:9])
      else $error("B to A transparent path wrong");
endmodule

bind sbt_scan_transceiver sbt_asserts u_sbtChk (.mclk(mclk), .reset(reset), .tck(tck),
   .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .aIn(aIn), .aOut(aOut), .aOe(aOe),
   .bIn(bIn), .bOut(bOut), .bOe(bOe), .aToBOutputEnableN(aToBOutputEnableN),
   .bToAOutputEnableN(bToAOutputEnableN), .aToBLatchEnable(aToBLatchEnable),
   .bToALatchEnable(bToALatchEnable), .aToBClock(aToBClock), .bToAClock(bToAClock));

// ===== tb/sbt_bus_partner.sv
// Far side of both buses plus the test pin pull-ups.
// Assumes one mclk; the design's drivers win over the far side.
`timescale 1ns/1ps
module sbt_bus_partner (
   input wire mclk,
   input wire [17:0] aOut,
   input wire [17:0] aOe,
   input wire [17:0] bOut,
   input wire [17:0] bOe,
   input wire [17:0] farA,
   input wire [17:0] farAEn,
   input wire [17:0] farB,
   input wire [17:0] farBEn,
   input wire tmsDrv,
   input wire tmsEn,
   input wire tdiDrv,
   input wire tdiEn,
   output wire [17:0] aIn,
   output wire [17:0] bIn,
   output wire tms,
   output wire tdi
);
   reg [17:0] aPrev_r = 18'h0;
   reg [17:0] bPrev_r = 18'h0;
   assign tms = tmsEn ? tmsDrv : 1'b1;
   assign tdi = tdiEn ? tdiDrv : 1'b1;
   // Floating lines toggle so a stale level never passes for data
   assign aIn = (aOe & aOut) | (~aOe & farAEn & farA) | (~aOe & ~farAEn & ~aPrev_r);
   assign bIn = (bOe & bOut) | (~bOe & farBEn & farB) | (~bOe & ~farBEn & ~bPrev_r);
   always @(posedge mclk) begin
      aPrev_r <= aIn;
      bPrev_r <= bIn;
   end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the scan test bus transceiver.
// Assumes the partner resolves bus wires; tck stands low outside frames.
`timescale 1ns/1ps
`include "sbt_defs.vh"
module tb_top;
   // Identification value is arbitrary
   localparam [31:0] ID_VAL = 32'h1357a2c9;
   localparam [83:0] PRE = {4'hc, 8'h00, 18'h0, 18'h0, 18'h1e0f3, 18'h0};
   reg mclk = 1'b0;
   reg reset = 1'b1;
   reg tck = 1'b0;
   reg tmsDrv = 1'b1;
   reg tmsEn = 1'b1;
   reg tdiDrv = 1'b1;
   reg tdiEn = 1'b1;
   reg [17:0] farA = 18'h0;
   reg [17:0] farAEn = 18'h3ffff;
   reg [17:0] farB = 18'h0;
   reg [17:0] farBEn = 18'h0;
   reg [1:0] aToBOutputEnableN = 2'b11;
   reg [1:0] bToAOutputEnableN = 2'b11;
   reg [1:0] aToBLatchEnable = 2'b00;
   reg [1:0] bToALatchEnable = 2'b00;
   reg [1:0] aToBClock = 2'b00;
   reg [1:0] bToAClock = 2'b00;
   wire tms, tdi, tdo, tdoOe;
   wire [17:0] aIn, aOut, aOe, bIn, bOut, bOe;
   integer failCount = 0;
   integer compares = 0;
   integer k;
   reg [83:0] d;
   reg oeRise;
   always #5 mclk = ~mclk;
   sbt_scan_transceiver #(.ID_VALUE(ID_VAL)) dut (.mclk(mclk), .reset(reset), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .aIn(aIn), .aOut(aOut), .aOe(aOe),
      .bIn(bIn), .bOut(bOut), .bOe(bOe), .aToBOutputEnableN(aToBOutputEnableN),
      .bToAOutputEnableN(bToAOutputEnableN), .aToBLatchEnable(aToBLatchEnable),
      .bToALatchEnable(bToALatchEnable), .aToBClock(aToBClock), .bToAClock(bToAClock));
   sbt_bus_partner u_partner (.mclk(mclk), .aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe),
      .farA(farA), .farAEn(farAEn), .farB(farB), .farBEn(farBEn), .tmsDrv(tmsDrv),
      .tmsEn(tmsEn), .tdiDrv(tdiDrv), .tdiEn(tdiEn), .aIn(aIn), .bIn(bIn), .tms(tms),
      .tdi(tdi));
   task check(input [83:0] seen, input [83:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            failCount = failCount + 1;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
         end
      end
   endtask
   // Pins settle through the synchronisers
   task settle;
      repeat (8) @(negedge mclk);
   endtask
   // change on fall, sample on rise
   task tckBit(input t, input dIn, output o);
      begin
         tmsDrv = t;
         tdiDrv = dIn;
         #62.5 tck = 1'b1;
         o = tdo;
         oeRise = tdoOe;
         #62.5 tck = 1'b0;
      end
   endtask
   // Full scan from idle back to idle, low bit first
   task scan(input ir, input [83:0] din, input integer n, output [83:0] dout);
      reg b;
      reg oeSeen;
      integer i;
      begin
         dout = 84'h0;
         oeSeen = 1'b1;
         tckBit(1'b1, 1'b0, b);
         if (ir) tckBit(1'b1, 1'b0, b);
         tckBit(1'b0, 1'b0, b);
         tckBit(1'b0, 1'b0, b);
         for (i = 0; i < n; i = i + 1) begin
            // Enable only settles a few mclk after the tck fall
            tckBit(i == n - 1, din[i], b);
            oeSeen = oeSeen & oeRise;
            dout[i] = b;
         end
         tckBit(1'b1, 1'b0, b);
         tckBit(1'b0, 1'b0, b);
         check(oeSeen, 1'b1);
         check(tdoOe, 1'b0);
         @(negedge mclk);
      end
   endtask
   task tapReset;
      reg b;
      begin
         tmsEn = 1'b0;
         tdiEn = 1'b0;
         repeat (5) tckBit(1'b0, 1'b0, b);
         tmsEn = 1'b1;
         tdiEn = 1'b1;
         tckBit(1'b0, 1'b0, b);
         @(negedge mclk);
      end
   endtask
   task finalReport;
      begin
         $display("Comparisons %0d, mismatches %0d", compares, failCount);
         if (failCount == 0 && compares > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      settle;
      tapReset;
      scan(1'b0, 84'h0, 32, d);
      check(d[31:0], ID_VAL);
      for (k = 0; k < 2; k = k + 1) begin
         scan(1'b1, {76'h0, (k != 0) ? 8'h01 : `SBT_OP_BYPASS}, 8, d);
         check(d[7:0], `SBT_IR_CAPTURE);
         scan(1'b0, 84'ha5, 8, d);
         check(d[7:0], 8'h4a);
      end
      farA = 18'h2b3c5;
      aToBOutputEnableN = 2'b00;
      aToBLatchEnable = 2'b11;
      settle;
      check(bOut, 18'h2b3c5);
      check(bOe, 18'h3ffff);
      scan(1'b1, {76'h0, `SBT_OP_SAMPLE}, 8, d);
      farA = 18'h15a3c;
      settle;
      scan(1'b0, PRE, 84, d);
      check(d[17:0], 18'h15a3c);
      check(d[53:36], 18'h15a3c);
      check(d[83:72], 12'h30c);
      check(bOut, 18'h15a3c);
      aToBLatchEnable = 2'b00;
      settle;
      farA = 18'h3fe00;
      settle;
      check(bOut, 18'h15a3c);
      aToBClock = 2'b01;
      settle;
      check(bOut, 18'h15a00);
      aToBOutputEnableN = 2'b10;
      settle;
      check(bOe, 18'h001ff);
      aToBOutputEnableN = 2'b11;
      farB = 18'h2aa55;
      farBEn = 18'h3ffff;
      farAEn = 18'h001ff;
      bToAOutputEnableN = 2'b01;
      bToALatchEnable = 2'b10;
      settle;
      check(aOut[17:9], 9'h155);
      check(aOe, 18'h3fe00);
      bToAOutputEnableN = 2'b11;
      bToALatchEnable = 2'b00;
      farAEn = 18'h3ffff;
      farBEn = 18'h0;
      aToBOutputEnableN = 2'b00;
      aToBClock = 2'b00;
      settle;
      // Test mode drives from the preloaded cells, not the pins
      scan(1'b1, {76'h0, `SBT_OP_EXTEST}, 8, d);
      settle;
      check(aOut, 18'h1e0f3);
      check(aOe, 18'h3ffff);
      check(bOe, 18'h0);
      // One pattern step from the preloaded A out cells
      scan(1'b1, {76'h0, `SBT_OP_BCRSCAN}, 8, d);
      scan(1'b0, {82'h0, `SBT_BCR_PSEUDO_RANDOM_PATTERN_GEN}, 21, d);
      scan(1'b1, {76'h0, `SBT_OP_RUNTEST}, 8, d);
      tckBit(1'b0, 1'b0, d[0]);
      settle;
      check(aOut, 18'h3c1e6);
      tapReset;
      settle;
      check(aOe, 18'h0);
      check(bOe, 18'h3ffff);
      scan(1'b0, 84'h0, 32, d);
      check(d[31:0], ID_VAL);
      finalReport;
   end
   // Whole run needs well under this span
   initial begin
      #400000;
      failCount = failCount + 1;
      finalReport;
   end
endmodule
